/* hdl/csg_ctrl2.sv */
`timescale 1ns/1ps
`default_nettype none
`include "csg_defines.svh"

//////////////////////////////////////////////////////////////////////////////
// Operation
// RULE1: With sync bit set, steering changes apply only at rollover or reset.
// RULE2: Each set steering bit lets the unit drive its pin; clear releases it.
// RULE3: Steering bits for outputs B to F exist only in multi-output variant.
// RULE4: Gate mode 10: falling gate edge sets the capture-disable flag.
// RULE5: Gate mode 01: rising gate edge clears the capture-disable flag.
// RULE6: Gate mode 00: high gate level permits capture, low blocks; 11 reserved.
// RULE7: Aux select: off, rollover, mode signal, or capture/compare event.
// RULE8: Capture source picks pin, comparator 1/2 or logic cell 1/2.
// RULE9: Auto-restart clears shutdown flag at next period start after shutdown.
// RULE10: Without auto-restart software clears the shutdown flag; unit holds it.
// RULE11: Unimplemented bits read zero and ignore writes.
// RULE12: Shutdown gate mode, software shutdown, source enables stored, passed on.
module csg_ctrl2 #(
  parameter bit MULTI = 1'b1,
  parameter int OUTS = 6
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [`CSG_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic period_start,
  input wire logic capture_event,
  input wire logic compare_event,
  input wire logic timer_mode,
  input wire logic mode_signal,
  input wire logic shutdown_active,
  input wire logic gate_in,
  input wire logic capture_input_pin,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  input wire logic logic_cell_one,
  input wire logic logic_cell_two,
  input wire logic [OUTS-1:0] pwm_out,
  output logic [OUTS-1:0] compare_output_pin,
  output logic [OUTS-1:0] compare_output_oe,
  output logic capture_out,
  output logic capture_allowed,
  output logic aux_out,
  output logic shutdown_event_flag,
  output logic shutdown_gate_mode,
  output logic software_shutdown,
  output logic [7:0] shutdown_source_enables
);

  // Refused at elaboration, because the steering field has exactly six bits.
  if (OUTS != 6) begin : g_outs_check
    $error("csg_ctrl2 serves exactly six outputs");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic [1:0] gate_s1_r, gate_s1_nxt;
  logic [1:0] gate_s2_r, gate_s2_nxt;
  logic [4:0] src_s1_r, src_s1_nxt;
  logic [4:0] src_s2_r, src_s2_nxt;
  logic gate_d_r, gate_d_nxt;

  // Pins from other domains pass two flops so a metastable level never reaches
  // the gate edge detector, at the cost of two cycles of latency.
  always_comb begin
    gate_s1_nxt = {gate_in, 1'b0};
    gate_s2_nxt = gate_s1_r;
    src_s1_nxt = {logic_cell_two, logic_cell_one, cmp2_out, cmp1_out, capture_input_pin};
    src_s2_nxt = src_s1_r;
    gate_d_nxt = gate_s2_r[1];
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gate_s1_r <= 2'h0;
      gate_s2_r <= 2'h0;
      src_s1_r <= 5'h00;
      src_s2_r <= 5'h00;
      gate_d_r <= 1'b0;
    end else begin
      gate_s1_r <= gate_s1_nxt;
      gate_s2_r <= gate_s2_nxt;
      src_s1_r <= src_s1_nxt;
      src_s2_r <= src_s2_nxt;
      gate_d_r <= gate_d_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [OUTS-1:0] steer_act_r, steer_act_nxt;
  logic [`CSG_STAT_W-1:0] stat_r, stat_nxt;
  logic [`CSG_STAT_W-1:0] mask_r, mask_nxt;
  logic [31:0] rdata_nxt;
  logic sd_flag_r, sd_flag_nxt;
  logic cap_dis_r, cap_dis_nxt;
  logic [31:0] wmask;
  logic [`CSG_STAT_W-1:0] ev;
  logic gate_rise, gate_fall, sd_set;
  csg_pkg::csg_gate_t gmode;

  assign wmask = MULTI ? `CSG_CTRL_MASK_MULTI : `CSG_CTRL_MASK_SINGLE; // see RULE3
  assign gmode = csg_pkg::csg_gate_t'(ctrl_r[`CSG_BIT_GATE_HI:`CSG_BIT_GATE_LO]);
  assign gate_rise = gate_s2_r[1] & ~gate_d_r;
  assign gate_fall = ~gate_s2_r[1] & gate_d_r;
  assign sd_set = shutdown_active | ctrl_r[`CSG_BIT_SWSD];

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr && addr == `CSG_OFF_CTRL) begin
      ctrl_nxt = wdata & wmask; // see RULE11
    end
    // The active copy is what drives the pins; the control field only requests.
    // Holding it until rollover avoids a runt pulse in the middle of a period.
    steer_act_nxt = steer_act_r;
    if (!ctrl_r[`CSG_BIT_OUTPUT_ENABLE_SYNC] || period_start) begin
      steer_act_nxt = ctrl_r[`CSG_BIT_STEER_HI:`CSG_BIT_STEER_LO]; // see RULE1
    end
    cap_dis_nxt = cap_dis_r;
    unique case (gmode)
      csg_pkg::GATE_LEVEL: cap_dis_nxt = ~gate_s2_r[1]; // see RULE6
      csg_pkg::GATE_RISE_ENABLE: if (gate_rise) cap_dis_nxt = 1'b0; // see RULE5
      csg_pkg::GATE_FALL_DISABLE: if (gate_fall) cap_dis_nxt = 1'b1; // see RULE4
      csg_pkg::GATE_RESERVED: cap_dis_nxt = cap_dis_r;
    endcase
    // Software clear loses to a live shutdown so the event is never dropped.
    sd_flag_nxt = sd_flag_r;
    if (wr && addr == `CSG_OFF_STAT && wdata[`CSG_ST_SHUTDOWN]) begin
      sd_flag_nxt = 1'b0; // see RULE10
    end
    if (ctrl_r[`CSG_BIT_RESTART] && period_start && !sd_set) begin
      sd_flag_nxt = 1'b0; // see RULE9
    end
    if (sd_set) begin
      sd_flag_nxt = 1'b1;
    end
    ev = {cap_dis_nxt & ~cap_dis_r, capture_out & capture_allowed, sd_set & ~sd_flag_r};
    stat_nxt = stat_r;
    if (wr && addr == `CSG_OFF_STAT) begin
      stat_nxt = stat_r & ~wdata[`CSG_STAT_W-1:0];
    end
    stat_nxt = stat_nxt | ev;
    mask_nxt = mask_r;
    if (wr && addr == `CSG_OFF_MASK) begin
      mask_nxt = wdata[`CSG_STAT_W-1:0];
    end
    rdata_nxt = 32'h00000000;
    if (rd) begin
      unique case (addr)
        `CSG_OFF_CTRL: rdata_nxt = ctrl_r;
        `CSG_OFF_STAT: rdata_nxt = {29'h0, stat_r};
        `CSG_OFF_MASK: rdata_nxt = {29'h0, mask_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `CSG_CTRL_RESET;
      steer_act_r <= 6'h01;
      stat_r <= 3'h0;
      mask_r <= 3'h0;
      rdata <= 32'h00000000;
      sd_flag_r <= 1'b0;
      // Captures stay blocked after reset until the gate permits them.
      cap_dis_r <= 1'b1;
    end else begin
      ctrl_r <= ctrl_nxt;
      steer_act_r <= steer_act_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rdata <= rdata_nxt;
      sd_flag_r <= sd_flag_nxt;
      cap_dis_r <= cap_dis_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.
  always_comb begin
    unique case (ctrl_r[`CSG_BIT_SRC_HI:`CSG_BIT_SRC_LO]) // see RULE8
      3'h0: capture_out = src_s2_r[0];
      3'h1: capture_out = src_s2_r[1];
      3'h2: capture_out = src_s2_r[2];
      3'h4: capture_out = src_s2_r[3];
      3'h5: capture_out = src_s2_r[4];
      default: capture_out = 1'b0;
    endcase
    unique case (csg_pkg::csg_aux_t'(ctrl_r[`CSG_BIT_AUX_HI:`CSG_BIT_AUX_LO])) // see RULE7
      csg_pkg::AUX_OFF: aux_out = 1'b0;
      csg_pkg::AUX_ROLLOVER: aux_out = period_start;
      csg_pkg::AUX_MODE: aux_out = mode_signal;
      csg_pkg::AUX_EVENT: aux_out = ~timer_mode & (capture_event | compare_event);
    endcase
  end

  // Pins are driven while steered; during shutdown they stay enabled but are driven low.
  assign compare_output_oe = steer_act_r; // see RULE2
  assign compare_output_pin = steer_act_r & (sd_flag_r ? {OUTS{1'b0}} : pwm_out);
  assign capture_allowed = ~cap_dis_r;
  assign shutdown_event_flag = sd_flag_r;
  assign shutdown_gate_mode = ctrl_r[`CSG_BIT_SDGM]; // see RULE12
  assign software_shutdown = ctrl_r[`CSG_BIT_SWSD];
  assign shutdown_source_enables = ctrl_r[7:0];
  assign irq = |(stat_r & mask_r);

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  sync_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    ctrl_r[`CSG_BIT_OUTPUT_ENABLE_SYNC] && !period_start |=> $stable(steer_act_r)) // see RULE1
    else $error("steering changed without rollover");
  steer_imm_a: assert property (@(posedge clock) disable iff (!rstn)
    !ctrl_r[`CSG_BIT_OUTPUT_ENABLE_SYNC] |=> steer_act_r == $past(ctrl_r[29:24])) // see RULE2
    else $error("steering not applied immediately");
  single_var_a: assert property (@(posedge clock) disable iff (!rstn)
    !MULTI |-> ctrl_r[29:25] == 5'h00) // see RULE3
    else $error("single variant holds upper steering bits");
  fall_dis_a: assert property (@(posedge clock) disable iff (!rstn)
    gmode == csg_pkg::GATE_FALL_DISABLE && gate_fall |=> cap_dis_r) // see RULE4
    else $error("falling gate did not disable capture");
  rise_en_a: assert property (@(posedge clock) disable iff (!rstn)
    gmode == csg_pkg::GATE_RISE_ENABLE && gate_rise |=> !cap_dis_r) // see RULE5
    else $error("rising gate did not enable capture");
  level_gate_a: assert property (@(posedge clock) disable iff (!rstn)
    gmode == csg_pkg::GATE_LEVEL |=> cap_dis_r == !$past(gate_s2_r[1])) // see RULE6
    else $error("level gate mismatch");
  restart_clr_a: assert property (@(posedge clock) disable iff (!rstn)
    ctrl_r[15] && period_start && !sd_set |=> !sd_flag_r) // see RULE9
    else $error("auto restart did not clear shutdown flag");
  flag_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    sd_flag_r && !ctrl_r[15] && !(wr && addr == `CSG_OFF_STAT) |=> sd_flag_r) // see RULE10
    else $error("shutdown flag dropped without software");
  zero_bits_a: assert property (@(posedge clock) disable iff (!rstn)
    ctrl_r[30] == 1'b0 && ctrl_r[21] == 1'b0 && ctrl_r[11:8] == 4'h0) // see RULE11
    else $error("unimplemented bit set");
  sd_pass_a: assert property (@(posedge clock) disable iff (!rstn)
    wr && addr == `CSG_OFF_CTRL |=> shutdown_source_enables == $past(wdata[7:0])) // see RULE12
    else $error("shutdown sources not passed");
  // A stray drive on a released pin would fight whatever else owns the pin.
  pin_release_a: assert property (@(posedge clock) disable iff (!rstn) // see RULE2
    (compare_output_pin & ~compare_output_oe) == '0)
    else $error("released pin still driven");
  pin_shut_a: assert property (@(posedge clock) disable iff (!rstn) // see RULE10
    sd_flag_r |-> compare_output_pin == '0)
    else $error("pin active during shutdown");
  sd_set_a: assert property (@(posedge clock) disable iff (!rstn) // see RULE9
    sd_set |=> sd_flag_r)
    else $error("shutdown did not set flag");
  steer_sync_a: assert property (@(posedge clock) disable iff (!rstn) // see RULE1
    ctrl_r[`CSG_BIT_OUTPUT_ENABLE_SYNC] && period_start |=> steer_act_r == $past(ctrl_r[29:24]))
    else $error("steering not applied at rollover");
  single_oe_a: assert property (@(posedge clock) disable iff (!rstn) // see RULE3
    !MULTI |-> steer_act_r[OUTS-1:1] == '0)
    else $error("single variant steers upper outputs");
  rsv_hold_a: assert property (@(posedge clock) disable iff (!rstn) // see RULE6
    gmode == csg_pkg::GATE_RESERVED |=> $stable(cap_dis_r))
    else $error("reserved gate mode changed flag");
  aux_off_a: assert property (@(posedge clock) disable iff (!rstn) // see RULE7
    ctrl_r[20:19] == 2'h0 |-> !aux_out)
    else $error("aux active while disabled");
  aux_roll_a: assert property (@(posedge clock) disable iff (!rstn) // see RULE7
    ctrl_r[20:19] == 2'h1 |-> aux_out == period_start)
    else $error("aux not rollover");
  aux_timer_a: assert property (@(posedge clock) disable iff (!rstn) // see RULE7
    ctrl_r[20:19] == 2'h3 && timer_mode |-> !aux_out)
    else $error("aux event in timer mode");
  src_rsv_a: assert property (@(posedge clock) disable iff (!rstn) // see RULE8
    ctrl_r[18:16] inside {3'h3, 3'h6, 3'h7} |-> !capture_out)
    else $error("reserved source passes capture");
  src_pin_a: assert property (@(posedge clock) disable iff (!rstn) // see RULE8
    ctrl_r[18:16] == 3'h0 |-> capture_out == src_s2_r[0])
    else $error("capture pin not selected");
  rd_idle_a: assert property (@(posedge clock) disable iff (!rstn) // see RULE11
    !rd |=> rdata == 32'h00000000)
    else $error("read data without read");
  unmapped_a: assert property (@(posedge clock) disable iff (!rstn) // see RULE11
    rd && !(addr inside {`CSG_OFF_CTRL, `CSG_OFF_STAT, `CSG_OFF_MASK}) |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  gap_bit_a: assert property (@(posedge clock) disable iff (!rstn) // see RULE11
    ctrl_r[13] == 1'b0)
    else $error("unimplemented bit set");
  cap_stat_a: assert property (@(posedge clock) disable iff (!rstn)
    capture_out && capture_allowed |=> stat_r[`CSG_ST_CAPTURE])
    else $error("capture not recorded");
  mask_irq_a: assert property (@(posedge clock) disable iff (!rstn)
    (stat_r & mask_r) != '0 |-> irq)
    else $error("unmasked event without interrupt");
  stat_clear_a: assert property (@(posedge clock) disable iff (!rstn)
    wr && addr == `CSG_OFF_STAT && wdata[0] && !sd_set |=> !stat_r[`CSG_ST_SHUTDOWN])
    else $error("status bit not cleared");

endmodule
`default_nettype wire

/* inc/csg_defines.svh */
`ifndef CSG_DEFINES_SVH
`define CSG_DEFINES_SVH
`define CSG_ADDR_W 4
`define CSG_OFF_CTRL 4'h0
`define CSG_OFF_STAT 4'h4
`define CSG_OFF_MASK 4'h8
`define CSG_CTRL_RESET 32'h01000000
`define CSG_BIT_OUTPUT_ENABLE_SYNC 31
`define CSG_BIT_STEER_HI 29
`define CSG_BIT_STEER_LO 24
`define CSG_BIT_GATE_HI 23
`define CSG_BIT_GATE_LO 22
`define CSG_BIT_AUX_HI 20
`define CSG_BIT_AUX_LO 19
`define CSG_BIT_SRC_HI 18
`define CSG_BIT_SRC_LO 16
`define CSG_BIT_RESTART 15
`define CSG_BIT_SDGM 14
`define CSG_BIT_SWSD 12
`define CSG_CTRL_MASK_MULTI 32'hbfdfd0ff
`define CSG_CTRL_MASK_SINGLE 32'h81dfd0ff
`define CSG_STAT_W 3
`define CSG_ST_SHUTDOWN 0
`define CSG_ST_CAPTURE 1
`define CSG_ST_DISABLE 2
`endif

/* inc/csg_pkg.sv */
package csg_pkg;
  typedef enum logic [1:0] {
    GATE_LEVEL = 2'h0,
    GATE_RISE_ENABLE = 2'h1,
    GATE_FALL_DISABLE = 2'h2,
    GATE_RESERVED = 2'h3
  } csg_gate_t;
  typedef enum logic [1:0] {
    AUX_OFF = 2'h0,
    AUX_ROLLOVER = 2'h1,
    AUX_MODE = 2'h2,
    AUX_EVENT = 2'h3
  } csg_aux_t;
endpackage

/* tb/csg_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Comparators, logic cells, capture pin and gate source.
// They change on the clock so each new level is seen cleanly.
module csg_pins_model (
  input wire logic clock,
  input wire logic [5:0] pat,
  output logic capture_input_pin,
  output logic cmp1_out,
  output logic cmp2_out,
  output logic logic_cell_one,
  output logic logic_cell_two,
  output logic gate_in
);
  always_ff @(posedge clock) begin
    {gate_in, logic_cell_two, logic_cell_one, cmp2_out, cmp1_out, capture_input_pin} <= pat;
  end
endmodule
`default_nettype wire

/* tb/ccp_control2_steering_gating_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "csg_defines.svh"
////////////////////////////////////////////////////////////
module ccp_control2_steering_gating_test;
  logic clock = 0, rstn = 0, wr = 0, rd = 0, period_start = 0, capture_event = 0;
  logic compare_event = 0, timer_mode = 0, mode_signal = 0, shutdown_active = 0, pg, ea;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rv, d, seed;
  logic [5:0] pwm_out = 6'h2d, pat = 6'h0;
  logic [31:0] rdata;
  logic [5:0] compare_output_pin, compare_output_oe;
  logic irq, capture_out, capture_allowed, aux_out, shutdown_event_flag;
  logic shutdown_gate_mode, software_shutdown, capture_input_pin, cmp1_out, cmp2_out;
  logic logic_cell_one, logic_cell_two, gate_in;
  logic [7:0] shutdown_source_enables;
  logic [31:0] rdata_s, rs;
  logic [5:0] oe_s;
  logic [2:0] srcs [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
  logic [2:0] gt [9] = '{3'h1, 3'h0, 3'h3, 3'h2, 3'h5, 3'h4, 3'h5, 3'h6, 3'h7};
  int errors = 0, checks = 0;
  always #4 clock = ~clock;
  csg_ctrl2 dut (.*);
  csg_pins_model pm (.*);
  // A single-output instance shares all inputs and shows what it masks.
  csg_ctrl2 #(.MULTI(1'b0)) dut_single (.clock(clock), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_s), .irq(), .period_start(period_start),
    .capture_event(capture_event), .compare_event(compare_event), .timer_mode(timer_mode),
    .mode_signal(mode_signal), .shutdown_active(shutdown_active), .gate_in(gate_in),
    .capture_input_pin(capture_input_pin), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
    .logic_cell_one(logic_cell_one), .logic_cell_two(logic_cell_two), .pwm_out(pwm_out),
    .compare_output_pin(), .compare_output_oe(oe_s), .capture_out(), .capture_allowed(),
    .aux_out(), .shutdown_event_flag(), .shutdown_gate_mode(), .software_shutdown(),
    .shutdown_source_enables());
  function automatic logic [31:0] cw(logic s, logic [5:0] st, logic [1:0] g, a,
                                     logic [2:0] sr, logic rs);
    return {s, 1'b0, st, g, 1'b0, a, sr, rs, 15'h0};
  endfunction
  function automatic logic src_bit(logic [2:0] c, logic [5:0] p);
    return (c == 3'h0) ? p[0] : (c == 3'h1) ? p[1] : (c == 3'h2) ? p[2] :
           (c == 3'h4) ? p[3] : p[4];
  endfunction
  // The one-shot modes remember the last level, so the model needs the old gate too.
  function automatic logic gate_exp(logic [1:0] m, logic p, g, a);
    return (m == 2'h0) ? g : (m == 2'h1) ? (a | (g & ~p)) : (m == 2'h2) ? (a & ~(p & ~g)) : a;
  endfunction
  function automatic logic aux_exp(logic [1:0] a, logic [4:0] v);
    return (a == 2'h1) ? v[4] : (a == 2'h2) ? v[0] : (a == 2'h3) ? (~v[1] & (v[3] | v[2])) : 1'b0;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Each write is followed by an idle edge so no strobe is driven twice in one step.
  task automatic bw(input logic [3:0] a, input logic [31:0] v);
    addr <= a; wdata <= v; wr <= 1'b1; @(posedge clock); wr <= 1'b0; @(posedge clock);
  endtask
  task automatic br(input logic [3:0] a);
    addr <= a; rd <= 1'b1; @(posedge clock); rd <= 1'b0; #1 rv = rdata; rs = rdata_s;
    @(posedge clock);
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic sd_pulse();
    shutdown_active <= 1'b1; cy(1); shutdown_active <= 1'b0; cy(2);
  endtask
  task automatic ps_pulse();
    period_start <= 1'b1; cy(1); period_start <= 1'b0; cy(2);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    cy(20000);
    errors++;
    complete_run();
  end
  initial begin
    seed = $urandom(20);
    cy(20); rstn <= 1'b1; cy(1);
    br(4'h0); chk("ctrl", rv, 32'h01000000);
    br(4'h8); chk("mask", rv, 32'h0);
    br(4'hc); chk("unmapped", rv, 32'h0);
    chk("oe", 32'(compare_output_oe), 32'h1);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hffffffff : $urandom();
      bw(4'h0, d); br(4'h0);
      chk("ctrl", rv, d & `CSG_CTRL_MASK_MULTI);
      chk("ctrl_single", rs, d & `CSG_CTRL_MASK_SINGLE);
      chk("oe_single", 32'(oe_s & 6'h3e), 32'h0);
      chk("src_en", 32'(shutdown_source_enables), 32'(d[7:0]));
      chk("gate_md", 32'(shutdown_gate_mode), 32'(d[14]));
      chk("sw_sd", 32'(software_shutdown), 32'(d[12]));
    end
    $display("test fields done");
    bw(4'h0, cw(0, 6'h3f, 0, 0, 0, 0)); bw(4'h4, 32'h7); cy(1);
    chk("oe", 32'(compare_output_oe), 32'h3f);
    chk("pin", 32'(compare_output_pin), 32'h2d);
    bw(4'h0, cw(1, 6'h05, 0, 0, 0, 0)); cy(3);
    chk("oe", 32'(compare_output_oe), 32'h3f);
    ps_pulse();
    chk("oe", 32'(compare_output_oe), 32'h05);
    chk("pin", 32'(compare_output_pin), 32'h05);
    $display("test steer done");
    for (int i = 0; i < 15; i++) begin
      bw(4'h0, cw(0, 6'h01, 0, 0, srcs[i % 5], 0));
      pat <= 6'($urandom()); cy(6);
      chk("cap_src", 32'(capture_out), 32'(src_bit(srcs[i % 5], pat)));
    end
    $display("test source done");
    pg = pat[5];
    for (int i = 0; i < 9; i++) begin
      bw(4'h0, cw(0, 6'h01, gt[i][2:1], 0, 0, 0));
      pat <= {gt[i][0], 5'h0}; cy(6);
      ea = gate_exp(gt[i][2:1], pg, gt[i][0], ea); pg = gt[i][0];
      chk("allowed", 32'(capture_allowed), 32'(ea));
    end
    $display("test gate done");
    for (int i = 0; i < 16; i++) begin
      if (i % 4 == 0) bw(4'h0, cw(0, 6'h01, 0, 2'(i / 4), 0, 0));
      d = $urandom();
      {period_start, capture_event, compare_event, timer_mode, mode_signal} <= d[4:0];
      #1 chk("aux", 32'(aux_out), 32'(aux_exp(2'(i / 4), d[4:0])));
      @(posedge clock);
    end
    {period_start, capture_event, compare_event, timer_mode, mode_signal} <= 5'h0;
    $display("test aux done");
    bw(4'h0, cw(0, 6'h3f, 0, 0, 0, 0)); bw(4'h8, 32'h1); sd_pulse();
    chk("sd_flag", 32'(shutdown_event_flag), 32'h1);
    chk("pin", 32'(compare_output_pin), 32'h0);
    chk("irq", 32'(irq), 32'h1);
    ps_pulse(); br(4'h4);
    chk("sd_flag", 32'(shutdown_event_flag), 32'h1);
    chk("status", 32'(rv[0]), 32'h1);
    bw(4'h8, 32'h0);
    chk("irq", 32'(irq), 32'h0);
    bw(4'h4, 32'h1);
    chk("sd_flag", 32'(shutdown_event_flag), 32'h0);
    chk("pin", 32'(compare_output_pin), 32'h2d);
    bw(4'h0, cw(0, 6'h3f, 0, 0, 0, 1)); shutdown_active <= 1'b1; cy(1); ps_pulse();
    chk("sd_flag", 32'(shutdown_event_flag), 32'h1);
    shutdown_active <= 1'b0; cy(2); ps_pulse();
    chk("sd_flag", 32'(shutdown_event_flag), 32'h0);
    $display("test shutdown done");
    complete_run();
  end
endmodule
`default_nettype wire
